// ===== design/itm_pkg.sv
// Constants, command codes and carrier types of the timer, transition and action-mode configuration block.
package itm_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [7:0] OFS_DATA_LOW = 8'h00;
   localparam logic [7:0] OFS_DATA_HIGH = 8'h04;
   localparam logic [7:0] OFS_COMMAND = 8'h08;
   localparam logic [7:0] OFS_OUT_VALUE = 8'h0c;
   localparam logic [7:0] OFS_IN_VALUE = 8'h10;
   localparam logic [7:0] OFS_TRAP = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFS_READ_DATA = 8'h1c;

   // Command codes written to the command register.
   localparam logic [7:0] CMD_TIMER_VALUE = 8'hc3;
   localparam logic [7:0] CMD_TRANS_EN_12 = 8'hc4;
   localparam logic [7:0] CMD_TRANS_EN_34 = 8'hc5;
   localparam logic [7:0] CMD_TRANS_DIR_12 = 8'hc6;
   localparam logic [7:0] CMD_TRANS_DIR_34 = 8'hc7;
   localparam logic [7:0] CMD_ACTION_MODE = 8'hc8;
   localparam logic [7:0] CMD_RD_TIMER_VALUE = 8'hd3;
   localparam logic [7:0] CMD_RD_TRANS_EN_12 = 8'hd4;
   localparam logic [7:0] CMD_RD_TRANS_EN_34 = 8'hd5;
   localparam logic [7:0] CMD_RD_TRANS_DIR_12 = 8'hd6;
   localparam logic [7:0] CMD_RD_TRANS_DIR_34 = 8'hd7;
   localparam logic [7:0] CMD_RD_ACTION_MODE = 8'hd8;
   localparam logic [7:0] CMD_RD_TIMER_COUNT = 8'hda;
   localparam logic [7:0] CMD_TIMER_START = 8'he0;
   localparam logic [7:0] CMD_TIMER_STOP = 8'he1;
   localparam logic [7:0] CMD_TIMER_RESTART = 8'he2;
   localparam logic [7:0] CMD_TIMER_HALT_CLEAR = 8'he3;
   localparam logic [7:0] CMD_TRAP_CLEAR = 8'he4;
   localparam logic [7:0] CMD_SIMUL_OUTPUT_SET = 8'hf0;
   localparam logic [7:0] CMD_SIMUL_INPUT_LATCH = 8'hf1;

   // Timing: the figures in their own units, cycle counts derived from the clock period.
   localparam int CLK_PERIOD_NS = 8;
   localparam int US_NS = 1000;
   localparam int MS_NS = 1000000;
   localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

   // Reset values.
   localparam logic [15:0] TIMER_VALUE_RESET = 16'h0000;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // Position of the unit bit in the stored timer word.
   localparam int TIMER_UNIT_BIT = 15;

   // Action-mode byte, sampled from the low data register.
   typedef struct packed {
      logic [1:0] spare;
      logic input_strobe_edge_sel;
      logic output_strobe_edge_sel;
      logic timed_simul_latch_en;
      logic strobe_cmd_simul_latch_en;
      logic timed_simul_output_en;
      logic strobe_cmd_simul_output_en;
   } itm_mode_t;

   // Interrupt enable byte, sampled from the high data register.
   typedef struct packed {
      logic [3:0] spare;
      logic trap_irq_en;
      logic output_strobe_irq_en;
      logic input_strobe_irq_en;
      logic timer_irq_en;
   } itm_irq_en_t;

   // Timer states, one-hot.
   typedef enum logic [1:0] {
      TMR_IDLE = 2'b01,
      TMR_RUN = 2'b10
   } itm_tmr_state_t;

endpackage

// ===== design/itm_config.sv
// Timer, input transition trapping and action-mode configuration block with an APB register port.
// Function
// - Timer count is 15 bits, 1 to 32767.
// - High data bit 7 picks microsecond or millisecond.
// - Time base divides clock to one unit.
// - Reset clears stored timer value.
// - Commands start, stop and read timer count.
// - Ports one/two transition enables from data.
// - Ports three/four transition enables from data.
// - Only enabled inputs trap transitions.
// - Ports one/two direction: 0 rising, 1 falling.
// - Ports three/four direction: 0 rising, 1 falling.
// - Direction change may trap a spurious transition.
// - Action mode from low, interrupts from high.
// - Strobe/command mode holds outputs until set.
// - Timed mode applies outputs at timer expiry.
// - Strobe/command latch captures inputs on event.
// - Timed latch captures inputs at timer expiry.
// - Output strobe edge: 0 rising, 1 falling.
// - Input strobe edge: 0 rising, 1 falling.
// - Timer expiry pulls interrupt low; status read clears.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps

module itm_config #(
   parameter int MS_CYCLES = itm_pkg::MS_CYCLES
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [31:0] port_in,
   output logic [31:0] port_out,
   input wire logic output_strobe_in,
   input wire logic input_strobe_in,
   output logic interrupt_out_n_o,
   output logic interrupt_out_n_oe_n
);

   // Every pin input passes two flops; the third stage is the previous sample used for edges.
   logic [33:0] sync_ff1;
   logic [33:0] sync_ff2;
   logic [33:0] sync_prev;
   logic [31:0] live_in;
   logic [31:0] prev_in;
   logic ostb_edge;
   logic istb_edge;

   // Configuration state.
   logic [7:0] data_low;
   logic [7:0] data_high;
   logic [15:0] timer_value;
   logic [31:0] trans_en;
   logic [31:0] trans_dir;
   itm_pkg::itm_mode_t mode;
   itm_pkg::itm_irq_en_t irq_en;

   // Timer state.
   itm_pkg::itm_tmr_state_t tmr_state;
   logic [16:0] pre_cnt;
   logic [14:0] tmr_count;
   logic tick;
   logic expire;
   logic [16:0] unit_last;

   // Data paths and flags.
   logic [31:0] out_value;
   logic [31:0] in_latched;
   logic [31:0] trap;
   logic [2:0] irq_status;
   logic [15:0] read_data;

   // Bus strobes.
   logic wr_fire;
   logic rd_fire;
   logic cmd_fire;
   logic [7:0] cmd;
   logic addr_ok;
   logic out_load;
   logic in_load;
   logic [31:0] trap_set;
   logic [31:0] next_prdata;

   // Two-flop synchroniser; only the second stage and later are read by logic.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sync_ff1 <= 34'h0_0000_0000;
         sync_ff2 <= 34'h0_0000_0000;
         sync_prev <= 34'h0_0000_0000;
      end else begin
         sync_ff1 <= {input_strobe_in, output_strobe_in, port_in};
         sync_ff2 <= sync_ff1;
         sync_prev <= sync_ff2;
      end
   end

   assign live_in = sync_ff2[31:0];
   assign prev_in = sync_prev[31:0];
   // Strobe edge selection: a set select bit picks the falling edge.
   assign ostb_edge = mode.output_strobe_edge_sel ? (sync_prev[32] & ~sync_ff2[32])
                                                  : (~sync_prev[32] & sync_ff2[32]);
   assign istb_edge = mode.input_strobe_edge_sel ? (sync_prev[33] & ~sync_ff2[33])
                                                 : (~sync_prev[33] & sync_ff2[33]);

   // APB decode; writes and reads take effect at the access edge.
   assign wr_fire = psel & penable & pready & pwrite;
   assign rd_fire = psel & penable & pready & ~pwrite;
   assign cmd_fire = wr_fire && (paddr == itm_pkg::OFS_COMMAND);
   assign cmd = pwdata[7:0];
   assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= itm_pkg::OFS_READ_DATA);

   // One wait-free access phase: pready and read data are registered during setup.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= itm_pkg::WORD_RESET;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         prdata <= (psel & ~penable & ~pwrite) ? next_prdata : itm_pkg::WORD_RESET;
      end
   end

   // Read mux; the data registers are write-only and read as zero.
   always_comb begin
      next_prdata = itm_pkg::WORD_RESET;
      case (paddr)
         itm_pkg::OFS_OUT_VALUE: next_prdata = out_value;
         itm_pkg::OFS_IN_VALUE: next_prdata = in_latched;
         itm_pkg::OFS_TRAP: next_prdata = trap;
         itm_pkg::OFS_IRQ_STATUS: next_prdata = {29'h0000_0000, irq_status};
         itm_pkg::OFS_READ_DATA: next_prdata = {16'h0000, read_data};
         default: next_prdata = itm_pkg::WORD_RESET;
      endcase
   end

   // The two parameter bytes the host loads before writing a command.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         data_low <= itm_pkg::BYTE_RESET;
         data_high <= itm_pkg::BYTE_RESET;
      end else if (wr_fire) begin
         if (paddr == itm_pkg::OFS_DATA_LOW) begin
            data_low <= pwdata[7:0];
         end
         if (paddr == itm_pkg::OFS_DATA_HIGH) begin
            data_high <= pwdata[7:0];
         end
      end
   end

   // Setting commands copy the data bytes at the edge the command lands.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         timer_value <= itm_pkg::TIMER_VALUE_RESET;
         trans_en <= itm_pkg::WORD_RESET;
         trans_dir <= itm_pkg::WORD_RESET;
         mode <= itm_pkg::itm_mode_t'(itm_pkg::BYTE_RESET);
         irq_en <= itm_pkg::itm_irq_en_t'(itm_pkg::BYTE_RESET);
      end else if (cmd_fire) begin
         case (cmd)
            // Range 1..32767 is the host's duty; bit 15 carries the unit.
            itm_pkg::CMD_TIMER_VALUE: timer_value <= {data_high, data_low};
            itm_pkg::CMD_TRANS_EN_12: trans_en[15:0] <= {data_high, data_low};
            itm_pkg::CMD_TRANS_EN_34: trans_en[31:16] <= {data_high, data_low};
            // A new direction may see a level already past the edge; software clears traps after it.
            itm_pkg::CMD_TRANS_DIR_12: trans_dir[15:0] <= {data_high, data_low};
            itm_pkg::CMD_TRANS_DIR_34: trans_dir[31:16] <= {data_high, data_low};
            itm_pkg::CMD_ACTION_MODE: begin
               mode <= itm_pkg::itm_mode_t'(data_low);
               irq_en <= itm_pkg::itm_irq_en_t'(data_high);
            end
            default: begin
            end
         endcase
      end
   end

   // Read-back commands leave their answer in the read data register.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         read_data <= 16'h0000;
      end else if (cmd_fire) begin
         case (cmd)
            itm_pkg::CMD_RD_TIMER_VALUE: read_data <= timer_value;
            itm_pkg::CMD_RD_TRANS_EN_12: read_data <= trans_en[15:0];
            itm_pkg::CMD_RD_TRANS_EN_34: read_data <= trans_en[31:16];
            itm_pkg::CMD_RD_TRANS_DIR_12: read_data <= trans_dir[15:0];
            itm_pkg::CMD_RD_TRANS_DIR_34: read_data <= trans_dir[31:16];
            itm_pkg::CMD_RD_ACTION_MODE: read_data <= {irq_en, mode};
            itm_pkg::CMD_RD_TIMER_COUNT: read_data <= {1'b0, tmr_count};
            default: begin
            end
         endcase
      end
   end

   // Timer run state, steered by the start and stop commands.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         tmr_state <= itm_pkg::TMR_IDLE;
      end else if (cmd_fire) begin
         case (cmd)
            itm_pkg::CMD_TIMER_START, itm_pkg::CMD_TIMER_RESTART: tmr_state <= itm_pkg::TMR_RUN;
            itm_pkg::CMD_TIMER_STOP, itm_pkg::CMD_TIMER_HALT_CLEAR: tmr_state <= itm_pkg::TMR_IDLE;
            default: tmr_state <= tmr_state;
         endcase
      end
   end

   // One tick per microsecond or millisecond at the 8 ns clock period the cycle counts assume.
   assign unit_last = timer_value[itm_pkg::TIMER_UNIT_BIT] ? 17'(MS_CYCLES - 1)
                                                          : 17'(itm_pkg::US_CYCLES - 1);
   // Compare at or above, so a unit switched to a shorter one mid-count does not wait for a wrap.
   assign tick = (tmr_state == itm_pkg::TMR_RUN) && (pre_cnt >= unit_last);
   // A value of zero never expires, so an unprogrammed timer stays quiet.
   assign expire = tick && (timer_value[14:0] != 15'h0000) && (tmr_count + 15'h0001 >= timer_value[14:0]);

   // Prescaler and unit counter; expiry reloads for continuous operation.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pre_cnt <= 17'h0_0000;
         tmr_count <= 15'h0000;
      end else if (cmd_fire && (cmd == itm_pkg::CMD_TIMER_RESTART || cmd == itm_pkg::CMD_TIMER_HALT_CLEAR)) begin
         pre_cnt <= 17'h0_0000;
         tmr_count <= 15'h0000;
      end else if (tmr_state == itm_pkg::TMR_RUN) begin
         pre_cnt <= tick ? 17'h0_0000 : pre_cnt + 17'h0_0001;
         if (expire) begin
            tmr_count <= 15'h0000;
         end else if (tick) begin
            tmr_count <= tmr_count + 15'h0001;
         end
      end
   end

   // Output events: set command or strobe edge in one mode, timer expiry in the other.
   assign out_load = (mode.strobe_cmd_simul_output_en &&
                      ((cmd_fire && cmd == itm_pkg::CMD_SIMUL_OUTPUT_SET) || ostb_edge)) ||
                     (mode.timed_simul_output_en && expire);

   // Written values wait in out_value; pins follow at once only when no holding mode is on.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         out_value <= itm_pkg::WORD_RESET;
         port_out <= itm_pkg::WORD_RESET;
      end else begin
         if (wr_fire && paddr == itm_pkg::OFS_OUT_VALUE) begin
            out_value <= pwdata;
         end
         if (out_load) begin
            port_out <= out_value;
         end else if (!mode.strobe_cmd_simul_output_en && !mode.timed_simul_output_en) begin
            port_out <= out_value;
         end
      end
   end

   // Input events mirror the output side.
   assign in_load = (mode.strobe_cmd_simul_latch_en &&
                     ((cmd_fire && cmd == itm_pkg::CMD_SIMUL_INPUT_LATCH) || istb_edge)) ||
                    (mode.timed_simul_latch_en && expire);

   // Latched inputs hold until the next event; with both modes off they track the pins.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         in_latched <= itm_pkg::WORD_RESET;
      end else if (in_load) begin
         in_latched <= live_in;
      end else if (!mode.strobe_cmd_simul_latch_en && !mode.timed_simul_latch_en) begin
         in_latched <= live_in;
      end
   end

   // Per-input trap detection, one instance per bit.
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_trap
         assign trap_set[gi] = trans_en[gi] && (trans_dir[gi] ? (prev_in[gi] & ~live_in[gi])
                                                               : (~prev_in[gi] & live_in[gi]));
      end
   endgenerate

   // Traps are sticky; a new trap in the clearing cycle survives the clear.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         trap <= itm_pkg::WORD_RESET;
      end else if (cmd_fire && cmd == itm_pkg::CMD_TRAP_CLEAR) begin
         trap <= trap_set;
      end else if (rd_fire && paddr == itm_pkg::OFS_TRAP) begin
         // Only the bits the reader was shown are cleared; a capture after the setup edge is kept.
         trap <= (trap & ~prdata) | trap_set;
      end else begin
         trap <= trap | trap_set;
      end
   end

   // Interrupt status: timer, input strobe, output strobe; a read clears only the bits it returned.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         irq_status <= 3'h0;
      end else begin
         irq_status <= ((rd_fire && paddr == itm_pkg::OFS_IRQ_STATUS) ? (irq_status & ~prdata[2:0]) : irq_status) |
                       {irq_en.output_strobe_irq_en & mode.strobe_cmd_simul_output_en & ostb_edge,
                        irq_en.input_strobe_irq_en & mode.strobe_cmd_simul_latch_en & istb_edge,
                        irq_en.timer_irq_en & expire};
      end
   end

   // Open-drain interrupt pin: level is always low, released by raising the enable.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         interrupt_out_n_oe_n <= 1'b1;
      end else begin
         interrupt_out_n_oe_n <= ~(|irq_status || (irq_en.trap_irq_en && |trap));
      end
   end
   assign interrupt_out_n_o = 1'b0;

   // Checks on the behaviour above.
   reset_value_a: assert property (@(posedge ref_clk) !resetn |=> timer_value == 16'h0000)
      else $error("timer value not zero after reset");

   trap_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      ((trap & ~$past(trap) & ~$past(trans_en)) == 32'h0000_0000))
      else $error("disabled input recorded a transition");

   enable_store_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      cmd_fire && cmd == 8'hc4 |=> trans_en[15:0] == $past({data_high, data_low}))
      else $error("first pair enables not stored");

   out_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      mode.strobe_cmd_simul_output_en && !mode.timed_simul_output_en && !out_load && !cmd_fire
      |=> $stable(port_out))
      else $error("held output changed without a set event");

   timed_output_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      mode.timed_simul_output_en && expire |=> port_out == $past(out_value))
      else $error("outputs not applied at timer expiry");

   latch_capture_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      mode.strobe_cmd_simul_latch_en && istb_edge |=> in_latched == $past(live_in))
      else $error("inputs not latched on strobe edge");

   timer_irq_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      irq_en.timer_irq_en && expire |=> irq_status[0] ##1 !interrupt_out_n_oe_n)
      else $error("timer expiry did not raise interrupt");

   us_tick_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      tick && !timer_value[15] && !cmd_fire |=> !tick [*8])
      else $error("microsecond ticks too close together");

   mode_store_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      cmd_fire && cmd == itm_pkg::CMD_ACTION_MODE |=> {irq_en, mode} == $past({data_high, data_low}))
      else $error("action mode or interrupt enables not stored");

   idle_count_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      tmr_state == itm_pkg::TMR_IDLE && !cmd_fire |=> $stable(tmr_count))
      else $error("stopped timer count moved");

   timed_latch_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      mode.timed_simul_latch_en && expire |=> in_latched == $past(live_in))
      else $error("inputs not latched at timer expiry");

   trap_edge_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      1'b1 |=> (trap & $past(trans_en & (trans_dir ^ live_in) & (prev_in ^ live_in))) ==
               $past(trans_en & (trans_dir ^ live_in) & (prev_in ^ live_in)))
      else $error("enabled transition in chosen direction not trapped");

   istb_irq_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      !mode.strobe_cmd_simul_latch_en && !irq_status[1] |=> !irq_status[1])
      else $error("input strobe interrupt without latch mode");

endmodule

// ===== verif/itm_host_model.sv
// Host processor model: an APB master that loads the data registers and issues commands.
`timescale 1ns/1ps

module itm_host_model (
   input wire logic ref_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic [31:0] rd;
   logic err;

   // The bus is idle from time zero, so nothing is requested while reset is held.
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end

   // One transfer; an edge passes first, so back-to-back calls never drive psel twice in one step.
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Both data bytes go first and the code last, so the device samples a complete pair.
   task automatic cmd(input logic [7:0] code, input logic [7:0] lo, input logic [7:0] hi);
      xfer(1'b1, itm_pkg::OFS_DATA_LOW, {24'h0, lo});
      xfer(1'b1, itm_pkg::OFS_DATA_HIGH, {24'h0, hi});
      xfer(1'b1, itm_pkg::OFS_COMMAND, {24'h0, code});
   endtask

   // A direction change is always followed by a trap clear, discarding any spurious capture.
   task automatic set_dir(input logic [7:0] code, input logic [7:0] lo, input logic [7:0] hi);
      cmd(code, lo, hi);
      xfer(1'b1, itm_pkg::OFS_COMMAND, {24'h0, itm_pkg::CMD_TRAP_CLEAR});
   endtask
endmodule

// ===== verif/test_itm_config.sv
// Self-checking bench of the timer, trapping and action-mode configuration block.
`timescale 1ns/1ps

module test_itm_config;
   localparam int MS_CYC = 250;
   // Rows: command, low byte, high byte, read-back command, expected read-back word.
   localparam logic [47:0] ROWS [7] = '{
      48'hc3_ff_7f_d3_7fff,
      48'hc3_01_80_d3_8001,
      48'hc4_a5_3c_d4_3ca5,
      48'hc5_5a_c3_d5_c35a,
      48'hc6_0f_f0_d6_f00f,
      48'hc7_f0_0f_d7_0ff0,
      48'hc8_3f_0f_d8_0f3f
   };
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, irq_o, irq_oe_n, cnt_ok;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, port_out;
   logic [31:0] port_in = 32'h0000_0000;
   logic ostb = 1'b0;
   logic istb = 1'b0;
   int fails = 0;
   int checked = 0;
   int cyc = 0;
   int t0;
   // The interrupt line is open drain with a pull-up, so released reads high.
   wire irq_n = irq_oe_n ? 1'b1 : irq_o;

   // Free-running clock and a cycle count for the timed checks.
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;

   itm_config #(.MS_CYCLES(MS_CYC)) dut_u (
      .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_in(port_in), .port_out(port_out), .output_strobe_in(ostb), .input_strobe_in(istb),
      .interrupt_out_n_o(irq_o), .interrupt_out_n_oe_n(irq_oe_n)
   );

   itm_host_model host_u (
      .ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      host_u.xfer(1'b0, a, 32'h0);
      chk(host_u.rd, exp, $sformatf("read at %h", a));
   endtask

   task automatic irq_is(input logic e);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq_n}, {31'h0, e}, "interrupt pin");
   endtask

   task automatic wr_cmd(input logic [7:0] code);
      host_u.xfer(1'b1, itm_pkg::OFS_COMMAND, {24'h0, code});
   endtask

   // Pins change on an edge; eight cycles cover the synchronisers and edge detectors.
   task automatic pins(input logic [31:0] v, input logic o, input logic i);
      @(posedge ref_clk);
      port_in <= v;
      ostb <= o;
      istb <= i;
      repeat (8) @(posedge ref_clk);
   endtask

   task automatic wait_to(input int t);
      while (cyc < t) @(posedge ref_clk);
   endtask

   task automatic close_out;
      $display("checks %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Main sequence: table rows, then reset, refusal, trapping, strobes and timer.
   initial begin
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      foreach (ROWS[k]) begin
         host_u.cmd(ROWS[k][47:40], ROWS[k][39:32], ROWS[k][31:24]);
         wr_cmd(ROWS[k][23:16]);
         rd_chk(itm_pkg::OFS_READ_DATA, {16'h0, ROWS[k][15:0]});
      end
      @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      wr_cmd(itm_pkg::CMD_RD_TIMER_VALUE);
      rd_chk(itm_pkg::OFS_READ_DATA, 32'h0);
      chk(port_out, 32'h0, "port_out after reset");
      host_u.xfer(1'b0, 8'h20, 32'h0);
      chk({31'h0, host_u.err}, 32'h1, "error on unmapped address");
      // Trapping: port_one bit 0 rising, port_four bit 7 falling, port_one bit 1 disabled.
      host_u.cmd(itm_pkg::CMD_TRANS_EN_12, 8'h01, 8'h00);
      host_u.cmd(itm_pkg::CMD_TRANS_EN_34, 8'h00, 8'h80);
      host_u.set_dir(itm_pkg::CMD_TRANS_DIR_34, 8'h00, 8'h80);
      pins(32'h8000_0003, 1'b0, 1'b0);
      rd_chk(itm_pkg::OFS_TRAP, 32'h0000_0001);
      pins(32'h0000_0000, 1'b0, 1'b0);
      rd_chk(itm_pkg::OFS_TRAP, 32'h8000_0000);
      host_u.set_dir(itm_pkg::CMD_TRANS_DIR_12, 8'h01, 8'h00);
      pins(32'h0000_0001, 1'b0, 1'b0);
      rd_chk(itm_pkg::OFS_TRAP, 32'h0);
      pins(32'h0000_0000, 1'b0, 1'b0);
      rd_chk(itm_pkg::OFS_TRAP, 32'h0000_0001);
      // Held outputs: released by the set command, then by each strobe edge polarity.
      host_u.cmd(itm_pkg::CMD_ACTION_MODE, 8'h01, 8'h04);
      host_u.xfer(1'b1, itm_pkg::OFS_OUT_VALUE, 32'ha5a5_5a5a);
      irq_is(1'b1);
      chk(port_out, 32'h0, "output held");
      wr_cmd(itm_pkg::CMD_SIMUL_OUTPUT_SET);
      irq_is(1'b1);
      chk(port_out, 32'ha5a5_5a5a, "output set");
      host_u.xfer(1'b1, itm_pkg::OFS_OUT_VALUE, 32'h1111_2222);
      pins(port_in, 1'b1, 1'b0);
      chk(port_out, 32'h1111_2222, "rising strobe");
      irq_is(1'b0);
      rd_chk(itm_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
      irq_is(1'b1);
      host_u.cmd(itm_pkg::CMD_ACTION_MODE, 8'h11, 8'h00);
      host_u.xfer(1'b1, itm_pkg::OFS_OUT_VALUE, 32'h3333_4444);
      irq_is(1'b1);
      chk(port_out, 32'h1111_2222, "held until falling strobe");
      pins(port_in, 1'b0, 1'b0);
      chk(port_out, 32'h3333_4444, "falling strobe");
      // Latched inputs: command, then each input strobe polarity; its interrupt needs the latch bit.
      host_u.cmd(itm_pkg::CMD_ACTION_MODE, 8'h04, 8'h02);
      pins(32'hdead_beef, 1'b0, 1'b0);
      wr_cmd(itm_pkg::CMD_SIMUL_INPUT_LATCH);
      rd_chk(itm_pkg::OFS_IN_VALUE, 32'hdead_beef);
      pins(32'h0bad_f00d, 1'b0, 1'b0);
      rd_chk(itm_pkg::OFS_IN_VALUE, 32'hdead_beef);
      pins(32'h0bad_f00d, 1'b0, 1'b1);
      rd_chk(itm_pkg::OFS_IN_VALUE, 32'h0bad_f00d);
      rd_chk(itm_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
      host_u.cmd(itm_pkg::CMD_ACTION_MODE, 8'h24, 8'h00);
      pins(32'h1234_5678, 1'b0, 1'b0);
      rd_chk(itm_pkg::OFS_IN_VALUE, 32'h1234_5678);
      // Microsecond timer of 3 counts: expiry falls between 250 and 375 cycles after start.
      host_u.cmd(itm_pkg::CMD_TIMER_VALUE, 8'h03, 8'h00);
      host_u.cmd(itm_pkg::CMD_ACTION_MODE, 8'h0a, 8'h01);
      host_u.xfer(1'b1, itm_pkg::OFS_OUT_VALUE, 32'h5555_aaaa);
      pins(32'h00c0_ffee, 1'b0, 1'b0);
      wr_cmd(itm_pkg::CMD_TIMER_START);
      t0 = cyc;
      wait_to(t0 + 240);
      chk(port_out, 32'h3333_4444, "timed output early");
      irq_is(1'b1);
      wait_to(t0 + 390);
      chk(port_out, 32'h5555_aaaa, "timed output");
      irq_is(1'b0);
      rd_chk(itm_pkg::OFS_IN_VALUE, 32'h00c0_ffee);
      rd_chk(itm_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
      irq_is(1'b1);
      wr_cmd(itm_pkg::CMD_TIMER_HALT_CLEAR);
      // Millisecond timer of 3 counts: expiry falls between 500 and 750 cycles.
      host_u.cmd(itm_pkg::CMD_TIMER_VALUE, 8'h03, 8'h80);
      wr_cmd(itm_pkg::CMD_TIMER_RESTART);
      t0 = cyc;
      wait_to(t0 + 480);
      irq_is(1'b1);
      wr_cmd(itm_pkg::CMD_RD_TIMER_COUNT);
      host_u.xfer(1'b0, itm_pkg::OFS_READ_DATA, 32'h0);
      cnt_ok = (host_u.rd[15:0] === 16'h0001) || (host_u.rd[15:0] === 16'h0002);
      chk({31'h0, cnt_ok}, 32'h1, "running count");
      wait_to(t0 + 770);
      irq_is(1'b0);
      wr_cmd(itm_pkg::CMD_TIMER_STOP);
      rd_chk(itm_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
      t0 = cyc;
      wait_to(t0 + 800);
      irq_is(1'b1);
      // Trap interrupt: the two captures still pending pull the pin until the trap read clears them.
      host_u.cmd(itm_pkg::CMD_ACTION_MODE, 8'h00, 8'h08);
      irq_is(1'b0);
      rd_chk(itm_pkg::OFS_TRAP, 32'h8000_0001);
      irq_is(1'b1);
      close_out();
   end

   // Watchdog: the sequence needs a few thousand cycles at most.
   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      $display("unexpected at %0t: watchdog expired", $time);
      close_out();
   end
endmodule
